// [inc/pseq_defines.svh]
// Purpose: constants for the program sequencer
// Assumes: single pclk domain
// Notes:   apb word offsets are byte addresses
`ifndef PSEQ_DEFINES_SVH
`define PSEQ_DEFINES_SVH
`define PSEQ_PC_W        15
`define PSEQ_CNT_W       13
`define PSEQ_BANK_W      2
`define PSEQ_STACK_DEPTH 12
`define PSEQ_SP_W        4
`define PSEQ_SP_FULL     4'hc
`define PSEQ_PHASE_LAST  2'h3
`define PSEQ_RESET_VEC   15'h0000
`define PSEQ_A_CTRL      12'h000
`define PSEQ_A_PCL       12'h004
`define PSEQ_A_BANK      12'h008
`define PSEQ_A_TBLP      12'h00c
`define PSEQ_A_TBHP      12'h010
`define PSEQ_A_TABLE_DATA_HIGH_BYTE      12'h014
`define PSEQ_A_STATUS    12'h018
`define PSEQ_A_PC        12'h01c
`define PSEQ_A_RESULT    12'h020
`define PSEQ_A_SECTOR    12'h024
`define PSEQ_A_ALU       12'h028
`define PSEQ_BANKS_1     2'h0
`define PSEQ_BANKS_2     2'h1
`endif

// [inc/pseq_pkg.sv]
// Purpose: types for the program sequencer
// Assumes: used with pseq_defines.svh
// Notes:   commands arrive through the control register
package pseq_pkg;
    typedef enum logic [3:0] {
        PSEQ_OP_NONE, PSEQ_OP_STEP, PSEQ_OP_JUMP, PSEQ_OP_CALL,
        PSEQ_OP_RET, PSEQ_OP_INTERRUPT_EXIT_OP, PSEQ_OP_SKIP, PSEQ_OP_IRQ,
        PSEQ_OP_TABRD, PSEQ_OP_EXTENDED_TABLE_READ_OP, PSEQ_OP_ADD, PSEQ_OP_SUB
    } pseq_op_t;
    typedef enum logic [1:0] {
        PSEQ_RUN, PSEQ_DUMMY, PSEQ_TABLE
    } pseq_state_t;
endpackage : pseq_pkg

// [verilog/pseq_core.sv]
// Purpose: program counter, return stack and table read sequencer
// Assumes: apb slave; ops issued by writing the control register
// Notes:   one instruction cycle is four pclk phases
//
// Summary of operation
// [RQ1] pc advances by one per instruction
// [RQ2] address is bank bits above 13-bit counter; code drives prog_addr from the 15-bit pc_reg, bank_reg unused
// [RQ3] pc low byte readable and writable
// [RQ4] jump, call, irq, reset load pc target
// [RQ5] taken skip discards prefetch with dummy cycle
// [RQ6] pc low write jumps within page, dummy
// [RQ7] twelve level stack hidden from software
// [RQ8] call or irq acknowledge pushes pc
// [RQ9] return pops stack into pc
// [RQ10] reset leaves stack empty
// [RQ11] full stack holds irq until return
// [RQ12] call on full stack drops oldest
// [RQ13] alu ops update carry and zero
// [RQ14] execution starts at address zero
// [RQ15] memory is one, two or four banks
// [RQ16] table pointers form full table address
// [RQ17] table read low to data, high kept
// [RQ18] normal read sector 0, extended others
// [RQ19] normal read offset within pointed page
// [RQ20] table instructions take two cycles
// [RQ21] software guards shared table high byte
// [RQ22] four phases, fetch starts at first
// [RQ23] table high byte holds until changed
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "pseq_defines.svh"
module pseq_core #(
    parameter logic [1:0] BANK_CFG = 2'h2
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        irq_request,
    input  wire logic [15:0] prog_word,
    output logic      [14:0] prog_addr,
    output logic             fetch_strobe,
    output logic      [7:0]  table_low_data,
    output logic             table_low_valid,
    output logic             irq_ack
);
    logic [`PSEQ_PC_W-1:0]   pc_reg;
    logic [`PSEQ_PC_W-1:0]   stack_reg [`PSEQ_STACK_DEPTH];
    logic [`PSEQ_SP_W-1:0]   sp_reg;
    logic [1:0]              phase_reg;
    logic [1:0]              bank_reg;
    logic [7:0]              tblp_reg;
    logic [7:0]              tbhp_reg;
    logic [7:0]              table_data_high_byte_reg;
    logic [7:0]              acc_reg;
    logic [7:0]              alu_result_reg;
    logic                    carry_reg;
    logic                    zero_reg;
    logic [1:0]              sector_reg;
    logic [`PSEQ_PC_W-1:0]   target_reg;
    pseq_pkg::pseq_op_t      op_reg;
    logic                    op_pending_reg;
    logic                    irq_pend_reg;
    logic                    pcl_wr_pending_reg;
    logic [7:0]              pcl_wdata_reg;
    logic                    sector_err_reg;
    pseq_pkg::pseq_state_t   state_reg;
    logic                    cyc_start;
    logic                    wr_en;
    logic                    rd_en;
    logic                    stack_full;
    logic                    irq_take;
    logic [`PSEQ_PC_W-1:0]   tbl_addr;
    logic [8:0]              alu_sum;

    function automatic logic [`PSEQ_PC_W-1:0] bank_mask(
        input logic [`PSEQ_PC_W-1:0] a
    );
        logic [`PSEQ_PC_W-1:0] m;
        m = a;
        if (BANK_CFG == `PSEQ_BANKS_1) begin
            m[14:13] = 2'h0;
        end else if (BANK_CFG == `PSEQ_BANKS_2) begin
            m[14] = 1'h0;
        end
        return m;
    endfunction : bank_mask

    function automatic logic hit(input logic [11:0] a);
        return psel && penable && (paddr == a);
    endfunction : hit

    assign cyc_start  = (phase_reg == `PSEQ_PHASE_LAST);
    assign wr_en      = psel && penable && pwrite;
    assign rd_en      = psel && penable && !pwrite;
    assign stack_full = (sp_reg == `PSEQ_SP_FULL);
    assign irq_take   = irq_pend_reg && !stack_full; // RQ11
    assign tbl_addr   = bank_mask({tbhp_reg[6:0], tblp_reg}); // RQ16 RQ19
    assign alu_sum    = (op_reg == pseq_pkg::PSEQ_OP_SUB)
                        ? {1'h0, acc_reg} - {1'h0, pwdata[7:0]}
                        : {1'h0, acc_reg} + {1'h0, pwdata[7:0]};

    // instruction cycle phases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1; // RQ22
        end
    end

    // command latch from control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_reg         <= pseq_pkg::PSEQ_OP_NONE;
            op_pending_reg <= 1'h0;
            target_reg     <= `PSEQ_RESET_VEC;
        end else if (wr_en && hit(`PSEQ_A_CTRL)) begin
            op_reg         <= pseq_pkg::pseq_op_t'(pwdata[3:0]);
            op_pending_reg <= 1'h1;
            target_reg     <= pwdata[30:16];
        end else if (cyc_start && state_reg == pseq_pkg::PSEQ_RUN) begin
            op_pending_reg <= 1'h0;
        end
    end

    // pc low byte write request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcl_wr_pending_reg <= 1'h0;
            pcl_wdata_reg      <= 8'h00;
        end else if (wr_en && hit(`PSEQ_A_PCL)) begin
            pcl_wr_pending_reg <= 1'h1; // RQ3
            pcl_wdata_reg      <= pwdata[7:0];
        end else if (cyc_start && state_reg == pseq_pkg::PSEQ_RUN) begin
            pcl_wr_pending_reg <= 1'h0;
        end
    end

    // interrupt request flag, set wins over acknowledge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pend_reg <= 1'h0;
        end else if (irq_request) begin
            irq_pend_reg <= 1'h1; // RQ11
        end else if (cyc_start && state_reg == pseq_pkg::PSEQ_RUN
                     && irq_take) begin
            irq_pend_reg <= 1'h0;
        end
    end

    // sequencer: pc, stack, dummy and table cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg          <= `PSEQ_RESET_VEC; // RQ4 RQ14
            sp_reg          <= '0; // RQ10
            state_reg       <= pseq_pkg::PSEQ_RUN;
            irq_ack         <= 1'h0;
            table_low_valid <= 1'h0;
            table_low_data  <= 8'h00;
            sector_err_reg  <= 1'h0;
            for (int i = 0; i < `PSEQ_STACK_DEPTH; i++) begin
                stack_reg[i] <= '0;
            end
        end else begin
            irq_ack         <= 1'h0;
            table_low_valid <= 1'h0;
            if (cyc_start) begin
                case (state_reg)
                pseq_pkg::PSEQ_DUMMY: begin
                    state_reg <= pseq_pkg::PSEQ_RUN; // RQ5 RQ6
                end
                pseq_pkg::PSEQ_TABLE: begin
                    // capture only once prog_addr has held the table address
                    table_low_data  <= prog_word[7:0]; // RQ17
                    table_low_valid <= 1'h1;
                    sector_err_reg  <=
                        (op_reg == pseq_pkg::PSEQ_OP_TABRD)
                        ? (sector_reg != 2'h0)
                        : (sector_reg == 2'h0); // RQ18
                    pc_reg    <= bank_mask(pc_reg + 15'h1); // RQ20
                    state_reg <= pseq_pkg::PSEQ_RUN;
                end
                pseq_pkg::PSEQ_RUN: begin
                    if (irq_take) begin
                        for (int i = `PSEQ_STACK_DEPTH - 1; i > 0; i--) begin
                            stack_reg[i] <= stack_reg[i-1];
                        end
                        stack_reg[0] <= pc_reg; // RQ8
                        sp_reg    <= sp_reg + 4'h1;
                        pc_reg    <= bank_mask(target_reg); // RQ4
                        irq_ack   <= 1'h1;
                        state_reg <= pseq_pkg::PSEQ_DUMMY;
                    end else if (pcl_wr_pending_reg) begin
                        pc_reg    <= {pc_reg[14:8], pcl_wdata_reg}; // RQ6
                        state_reg <= pseq_pkg::PSEQ_DUMMY;
                    end else if (op_pending_reg) begin
                        case (op_reg)
                        pseq_pkg::PSEQ_OP_JUMP: begin
                            pc_reg    <= bank_mask(target_reg); // RQ4
                            state_reg <= pseq_pkg::PSEQ_DUMMY;
                        end
                        pseq_pkg::PSEQ_OP_CALL: begin
                            for (int i = `PSEQ_STACK_DEPTH - 1; i > 0;
                                 i--) begin
                                stack_reg[i] <= stack_reg[i-1]; // RQ12
                            end
                            stack_reg[0] <= bank_mask(pc_reg + 15'h1); // RQ8
                            if (!stack_full) begin
                                sp_reg <= sp_reg + 4'h1;
                            end
                            pc_reg    <= bank_mask(target_reg);
                            state_reg <= pseq_pkg::PSEQ_DUMMY;
                        end
                        pseq_pkg::PSEQ_OP_RET,
                        pseq_pkg::PSEQ_OP_INTERRUPT_EXIT_OP: begin
                            pc_reg <= stack_reg[0]; // RQ9
                            for (int i = 0; i < `PSEQ_STACK_DEPTH - 1;
                                 i++) begin
                                stack_reg[i] <= stack_reg[i+1];
                            end
                            if (sp_reg != '0) begin
                                sp_reg <= sp_reg - 4'h1;
                            end
                            state_reg <= pseq_pkg::PSEQ_DUMMY;
                        end
                        pseq_pkg::PSEQ_OP_SKIP: begin
                            pc_reg    <= bank_mask(pc_reg + 15'h2); // RQ5
                            state_reg <= pseq_pkg::PSEQ_DUMMY;
                        end
                        pseq_pkg::PSEQ_OP_TABRD,
                        pseq_pkg::PSEQ_OP_EXTENDED_TABLE_READ_OP: begin
                            state_reg <= pseq_pkg::PSEQ_TABLE; // RQ20
                        end
                        default: begin
                            pc_reg <= bank_mask(pc_reg + 15'h1); // RQ1
                        end
                        endcase
                    end else begin
                        pc_reg <= bank_mask(pc_reg + 15'h1); // RQ1
                    end
                end
                default: begin
                    state_reg <= pseq_pkg::PSEQ_RUN;
                end
                endcase
            end
        end
    end

    // table data high byte: table read or software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_data_high_byte_reg <= 8'h00;
        end else if (cyc_start && state_reg == pseq_pkg::PSEQ_TABLE) begin
            table_data_high_byte_reg <= prog_word[15:8]; // RQ17
        end else if (wr_en && hit(`PSEQ_A_TABLE_DATA_HIGH_BYTE)) begin
            table_data_high_byte_reg <= pwdata[7:0]; // RQ23
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_reg   <= 2'h0;
            tblp_reg   <= 8'h00;
            tbhp_reg   <= 8'h00;
            sector_reg <= 2'h0;
        end else if (wr_en) begin
            if (hit(`PSEQ_A_BANK)) begin
                bank_reg <= pwdata[1:0] & BANK_CFG; // RQ15
            end
            if (hit(`PSEQ_A_TBLP)) begin
                tblp_reg <= pwdata[7:0];
            end
            if (hit(`PSEQ_A_TBHP)) begin
                tbhp_reg <= pwdata[7:0];
            end
            if (hit(`PSEQ_A_SECTOR)) begin
                sector_reg <= pwdata[1:0];
            end
        end
    end

    // alu flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg        <= 8'h00;
            alu_result_reg <= 8'h00;
            carry_reg      <= 1'h0;
            zero_reg       <= 1'h0;
        end else if (wr_en && hit(`PSEQ_A_ALU)) begin
            acc_reg <= pwdata[7:0];
        end else if (wr_en && hit(`PSEQ_A_RESULT)
                     && (op_reg == pseq_pkg::PSEQ_OP_ADD
                         || op_reg == pseq_pkg::PSEQ_OP_SUB)) begin
            alu_result_reg <= alu_sum[7:0];
            acc_reg        <= alu_sum[7:0];
            carry_reg      <= (op_reg == pseq_pkg::PSEQ_OP_SUB)
                              ? !alu_sum[8] : alu_sum[8]; // RQ13
            zero_reg       <= (alu_sum[7:0] == 8'h00); // RQ13
        end
    end

    // fetch address and strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_addr    <= `PSEQ_RESET_VEC;
            fetch_strobe <= 1'h0;
        end else begin
            fetch_strobe <= cyc_start && state_reg != pseq_pkg::PSEQ_TABLE;
            prog_addr    <= (state_reg == pseq_pkg::PSEQ_TABLE
                             || (op_pending_reg
                                 && (op_reg == pseq_pkg::PSEQ_OP_TABRD
                                  || op_reg == pseq_pkg::PSEQ_OP_EXTENDED_TABLE_READ_OP)))
                            ? tbl_addr : bank_mask(pc_reg); // RQ2
        end
    end

    // apb read path; stack and pointer not mapped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'h0;
            pslverr <= 1'h0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'h0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                `PSEQ_A_PCL:    prdata <= {24'h0, pc_reg[7:0]}; // RQ3
                `PSEQ_A_BANK:   prdata <= {30'h0, bank_reg};
                `PSEQ_A_TBLP:   prdata <= {24'h0, tblp_reg};
                `PSEQ_A_TBHP:   prdata <= {24'h0, tbhp_reg};
                `PSEQ_A_TABLE_DATA_HIGH_BYTE:   prdata <= {24'h0, table_data_high_byte_reg};
                `PSEQ_A_STATUS: prdata <= {24'h0, sector_err_reg, irq_pend_reg,
                                           stack_full, state_reg, zero_reg,
                                           carry_reg, op_pending_reg};
                `PSEQ_A_PC:     prdata <= {17'h0, pc_reg};
                `PSEQ_A_RESULT: prdata <= {24'h0, alu_result_reg};
                `PSEQ_A_SECTOR: prdata <= {30'h0, sector_reg};
                `PSEQ_A_ALU:    prdata <= {24'h0, acc_reg};
                `PSEQ_A_CTRL:   prdata <= {1'h0, target_reg, 12'h0, op_reg};
                default:        prdata <= 32'h0000_0000;
                endcase
            end
            if (psel && !penable) begin
                pslverr <= (paddr > `PSEQ_A_ALU) || (paddr[1:0] != 2'h0);
            end
        end
    end
    // RQ7: stack contents and sp have no bus path
    // RQ21: software disables interrupts around main table reads
endmodule : pseq_core

// [test/pseq_prog_mem.sv]
// Purpose: program memory model at the sequencer's far side
// Assumes: combinational read of 32K words
// Notes:   word contents follow a fixed address pattern
`timescale 1ns/10ps
module pseq_prog_mem (
    input  wire logic [14:0] prog_addr,
    output logic      [15:0] prog_word
);
    // high byte from low address bits, low byte from upper bits
    assign prog_word = {prog_addr[7:0] ^ 8'h5a, prog_addr[14:7]};
endmodule : pseq_prog_mem

// [test/pseq_core_monitor.sv]
// Purpose: port checks for the program sequencer
// Assumes: single pclk domain, async active low reset
// Notes:   bound to pseq_core at the foot of this file
`timescale 1ns/10ps
module pseq_core_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] prog_word,
    input wire logic [14:0] prog_addr,
    input wire logic        fetch_strobe,
    input wire logic [7:0]  table_low_data,
    input wire logic        table_low_valid,
    input wire logic        irq_ack
);
    logic [7:0] word_low_q;

    always_ff @(posedge pclk) begin
        word_low_q <= prog_word[7:0];
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        psel && penable && pready;
    endsequence
    sequence s_bad_setup;
        psel && !penable && (paddr > 12'h028);
    endsequence
    sequence s_refusal;
        pready && pslverr && (prdata == 32'h0);
    endsequence

    property p_apb_answer;
        s_setup |=> s_answer;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("no pready after setup");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready longer than one cycle");
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("pslverr without pready");
    property p_err_unmapped;
        s_bad_setup |=> s_refusal;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("unmapped access not refused");
    property p_table_data;
        table_low_valid |-> table_low_data == word_low_q;
    endproperty
    a_table_data: assert property (p_table_data)
        else $error("table low byte differs from word");
    property p_table_cycles;
        table_low_valid |=> !table_low_valid [*7];
    endproperty
    a_table_cycles: assert property (p_table_cycles)
        else $error("table read shorter than two cycles");
    property p_fetch_gap;
        fetch_strobe |=> !fetch_strobe [*3];
    endproperty
    a_fetch_gap: assert property (p_fetch_gap)
        else $error("fetch closer than one instruction cycle");
    property p_irq_gap;
        irq_ack |=> !irq_ack [*7];
    endproperty
    a_irq_gap: assert property (p_irq_gap)
        else $error("irq ack repeated too soon");
    property p_reset_vec;
        $rose(presetn) |-> prog_addr == 15'h0000;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("fetch address not zero after reset");
endmodule : pseq_core_monitor

bind pseq_core pseq_core_monitor u_pseq_core_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prog_word(prog_word), .prog_addr(prog_addr),
    .fetch_strobe(fetch_strobe), .table_low_data(table_low_data),
    .table_low_valid(table_low_valid), .irq_ack(irq_ack));

// [test/tb_top.sv]
// Purpose: self-checking bench for the program sequencer
// Assumes: 25 MHz pclk, apb master in this file
// Notes:   program memory comes from pseq_prog_mem
`timescale 1ns/10ps
`include "pseq_defines.svh"
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        irq_request, fetch_strobe, table_low_valid, irq_ack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] prog_word;
    logic [14:0] prog_addr, p;
    logic [7:0]  table_low_data;
    int          fail_count, comparisons, n;

    pseq_core #(.BANK_CFG(2'h3)) u_pseq_core (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_request(irq_request),
        .prog_word(prog_word), .prog_addr(prog_addr),
        .fetch_strobe(fetch_strobe), .table_low_data(table_low_data),
        .table_low_valid(table_low_valid), .irq_ack(irq_ack));
    pseq_prog_mem u_pseq_prog_mem (.prog_addr(prog_addr),
        .prog_word(prog_word));

    always #20 pclk = ~pclk;

    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rng(input string nm, input logic [14:0] lo, hi, g);
        chk(nm, 32'h1, {31'h0, (g >= lo) && (g <= hi)});
    endtask : rng

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        rd = prdata;
        er = pslverr;
        chk("pready", 32'h1, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic op(input pseq_pkg::pseq_op_t c, input logic [14:0] t);
        apb(1'b1, `PSEQ_A_CTRL, {1'b0, t, 12'h000, c});
        repeat (16) @(posedge pclk);
    endtask : op

    task automatic acks(input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge pclk);
            if (irq_ack === 1'b1) n++;
        end
    endtask : acks

    task automatic tab(input pseq_pkg::pseq_op_t c, input logic [14:0] a);
        logic [15:0] w;
        w = {a[7:0] ^ 8'h5a, a[14:7]};
        apb(1'b1, `PSEQ_A_CTRL, {28'h0, c});
        n = 0;
        while (table_low_valid !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk("table valid", 32'h1, {31'h0, table_low_valid});
        chk("table low", {24'h0, w[7:0]}, {24'h0, table_low_data});
        repeat (8) @(posedge pclk);
        apb(1'b0, `PSEQ_A_TABLE_DATA_HIGH_BYTE, 32'h0);
        chk("table high", {24'h0, w[15:8]}, {24'h0, rd[7:0]});
        apb(1'b0, `PSEQ_A_STATUS, 32'h0);
        chk("sector err", 32'h0, {31'h0, rd[7]});
    endtask : tab

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    task automatic t_reset();
        do_reset();
        apb(1'b0, `PSEQ_A_PC, 32'h0);
        rng("pc after reset", 15'h0000, 15'h0002, rd[14:0]);
        p = rd[14:0];
        repeat (9) @(posedge pclk);
        apb(1'b0, `PSEQ_A_PC, 32'h0);
        chk("pc step", 32'h3, {17'h0, rd[14:0] - p});
        apb(1'b0, `PSEQ_A_STATUS, 32'h0);
        chk("stack empty", 32'h0, {31'h0, rd[5]});
        apb(1'b0, 12'h030, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, 12'h006, 32'h0);
        chk("unaligned err", 32'h1, {31'h0, er});
        apb(1'b1, `PSEQ_A_BANK, 32'h3);
        apb(1'b0, `PSEQ_A_BANK, 32'h0);
        chk("bank select", 32'h3, {30'h0, rd[1:0]});
        $display("test reset done");
    endtask : t_reset

    task automatic t_jump();
        op(pseq_pkg::PSEQ_OP_JUMP, 15'h5234);
        apb(1'b0, `PSEQ_A_PC, 32'h0);
        rng("jump target", 15'h5234, 15'h523c, rd[14:0]);
        apb(1'b1, `PSEQ_A_PCL, 32'h10);
        repeat (12) @(posedge pclk);
        apb(1'b0, `PSEQ_A_PC, 32'h0);
        rng("pcl jump", 15'h5210, 15'h5218, rd[14:0]);
        apb(1'b0, `PSEQ_A_PCL, 32'h0);
        rng("pcl read", 15'h0010, 15'h0019, {7'h0, rd[7:0]});
        p = rd[14:0];
        op(pseq_pkg::PSEQ_OP_SKIP, 15'h0000);
        apb(1'b0, `PSEQ_A_PCL, 32'h0);
        rng("skip", p + 15'h4, p + 15'h8, {7'h0, rd[7:0]});
        $display("test jump done");
    endtask : t_jump

    task automatic t_stack();
        do_reset();
        apb(1'b0, `PSEQ_A_PC, 32'h0);
        p = rd[14:0];
        op(pseq_pkg::PSEQ_OP_CALL, 15'h0400);
        op(pseq_pkg::PSEQ_OP_RET, 15'h0000);
        apb(1'b0, `PSEQ_A_PC, 32'h0);
        rng("return pc", p, p + 15'h000c, rd[14:0]);
        for (int i = 0; i < 12; i++) begin
            op(pseq_pkg::PSEQ_OP_CALL, 15'h0100 + 15'(i * 16));
        end
        apb(1'b0, `PSEQ_A_STATUS, 32'h0);
        chk("full after 12", 32'h1, {31'h0, rd[5]});
        irq_request <= 1'b1;
        @(posedge pclk);
        irq_request <= 1'b0;
        acks(24);
        chk("ack on full", 32'h0, n);
        apb(1'b0, `PSEQ_A_STATUS, 32'h0);
        chk("irq pending", 32'h1, {31'h0, rd[6]});
        apb(1'b1, `PSEQ_A_CTRL, {28'h0, pseq_pkg::PSEQ_OP_RET});
        acks(24);
        chk("ack after ret", 32'h1, n);
        op(pseq_pkg::PSEQ_OP_CALL, 15'h0600);
        apb(1'b0, `PSEQ_A_STATUS, 32'h0);
        chk("full after overflow", 32'h1, {31'h0, rd[5]});
        for (int i = 0; i < 13; i++) begin
            op(i[0] ? pseq_pkg::PSEQ_OP_INTERRUPT_EXIT_OP : pseq_pkg::PSEQ_OP_RET,
               15'h0000);
        end
        apb(1'b0, `PSEQ_A_PC, 32'h0);
        rng("oldest lost", 15'h0100, 15'h011f, rd[14:0]);
        $display("test stack done");
    endtask : t_stack

    task automatic t_table();
        apb(1'b1, `PSEQ_A_TBLP, 32'h06);
        apb(1'b1, `PSEQ_A_TBHP, 32'h7f);
        apb(1'b1, `PSEQ_A_SECTOR, 32'h0);
        tab(pseq_pkg::PSEQ_OP_TABRD, 15'h7f06);
        apb(1'b1, `PSEQ_A_TBLP, 32'h05);
        apb(1'b1, `PSEQ_A_SECTOR, 32'h1);
        tab(pseq_pkg::PSEQ_OP_EXTENDED_TABLE_READ_OP, 15'h7f05);
        apb(1'b1, `PSEQ_A_TABLE_DATA_HIGH_BYTE, 32'h3c);
        repeat (16) @(posedge pclk);
        apb(1'b0, `PSEQ_A_TABLE_DATA_HIGH_BYTE, 32'h0);
        chk("table_data_high_byte kept", 32'h3c, {24'h0, rd[7:0]});
        $display("test table done");
    endtask : t_table

    task automatic t_alu();
        apb(1'b1, `PSEQ_A_ALU, 32'hf0);
        op(pseq_pkg::PSEQ_OP_ADD, 15'h0000);
        apb(1'b1, `PSEQ_A_RESULT, 32'h20);
        apb(1'b0, `PSEQ_A_RESULT, 32'h0);
        chk("add result", 32'h10, rd);
        apb(1'b0, `PSEQ_A_STATUS, 32'h0);
        chk("add flags", 32'h1, {30'h0, rd[2:1]});
        op(pseq_pkg::PSEQ_OP_SUB, 15'h0000);
        apb(1'b1, `PSEQ_A_RESULT, 32'h10);
        apb(1'b0, `PSEQ_A_STATUS, 32'h0);
        chk("sub flags", 32'h3, {30'h0, rd[2:1]});
        $display("test alu done");
    endtask : t_alu

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        irq_request = 1'b0;
        fail_count = 0;
        comparisons = 0;
        t_reset();
        t_jump();
        t_table();
        t_alu();
        t_stack();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        $display("Error watchdog expected done seen hang");
        close_out();
    end
endmodule : tb_top
